/* File: hdl/ekw_pkg.sv */
// Constants, register map and carrier types for the key and warning resources.
// Assumes one 25 MHz clock and an AHB-Lite register port with 32-bit data.
package ekw_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] REG_DATA_LO = 8'h00;
  localparam logic [7:0] REG_DATA_HI = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_OFFSET = 8'h0C;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_LEVEL = 8'h18;

  localparam logic [7:0] CTRL_START = 8'h01;
  localparam int ST_RELEASE = 0;
  localparam int ST_TXN_ERR = 1;
  localparam int ST_ENC_ERR = 2;
  localparam int ADDR_READ_BIT = 6;
  localparam int ADDR_DEF_BIT = 7;

  // ****************************************
  // Resources and defining values
  // ****************************************
  localparam logic [9:0] RID_KEY = 10'h105;
  localparam logic [9:0] RID_WARN = 10'h107;
  localparam logic [7:0] DEF_SIZE = 8'h08;
  localparam logic [7:0] DEF_OVERRUN = 8'h5A;
  localparam logic [7:0] DEF_TYPE = 8'h18;
  localparam logic [7:0] KEY_RD_LVL = 8'h0F;
  localparam logic [7:0] KEY_WR_LVL = 8'h00;
  localparam logic [7:0] WARN_RD_LVL = 8'h00;
  localparam logic [7:0] WARN_WR_LVL = 8'h02;
  localparam logic [7:0] MAX_LEVEL = 8'h04;
  localparam logic [7:0] MAX_WARN_OFF = 8'h1F;
  localparam int NUM_LEVELS = 5;
  localparam int NUM_WARN = 16;
  localparam int WARN_THR_BIT = 4;
  localparam logic [4:0][31:0] KEY_DEFAULT = {32'h34343434, 32'h33333333, 32'h32323232, 32'h31313131, 32'h00000000};

  // ****************************************
  // Warning encodings
  // ****************************************
  localparam logic [2:0] WT_OFF = 3'h0;
  localparam logic [2:0] WT_BELOW = 3'h1;
  localparam logic [2:0] WT_ABOVE = 3'h2;
  localparam logic [2:0] WT_BIT_CLR = 3'h3;
  localparam logic [2:0] WT_BIT_SET = 3'h4;
  localparam logic [1:0] FW_16 = 2'h1;
  localparam logic [1:0] FW_32 = 2'h2;
  localparam logic [1:0] FW_64 = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ = 25000;
  localparam int SCAN_PERIOD_MS = 1000;
  localparam int SCAN_CYCLES = CLK_KHZ * SCAN_PERIOD_MS;

  typedef enum logic {ST_IDLE = 1'b0, ST_EXEC = 1'b1} ekw_state_e;
  typedef enum logic [1:0] {SC_IDLE = 2'b00, SC_REQ = 2'b01, SC_EVAL = 2'b10} ekw_scan_e;

  typedef struct packed {
    logic [2:0] wtype;
    logic [2:0] fmt;
    logic [9:0] resIdx;
    logic [15:0] resOff;
  } ekw_cfg_s;

  typedef struct packed {
    logic [9:0] resIdx;
    logic [15:0] resOff;
  } ekw_mon_s;

endpackage

/* File: hdl/ekw_key_warn.sv */
// Key-change and user-warning resources of the encoder parameter channel.
// Assumes an AHB-Lite master on mclk and a monitored-value source that shows
// monValue in the same cycle in which the registered monitor strobe stands.
`timescale 1ns/1ps

// Contract
// [RULE1] Key resource defining read gives 105h, 8 bytes, levels 15/0, overrun 90, struct.
// [RULE2] Master sends old key, new key and target level in one write.
// [RULE3] Any level's key may be changed regardless of active level.
// [RULE4] Old key in bytes 7..4, new key in bytes 3..0.
// [RULE5] Reads of the key resource are refused.
// [RULE6] Offset gives key target level, valid 0 to 4.
// [RULE7] Master loads buffer, address 3D/05, offset, control 01, waits for release.
// [RULE8] Every enabled warning is evaluated once per second.
// [RULE9] A tripped warning raises encoder error and logs to error history.
// [RULE10] Warning resource defining read gives 107h, 8 bytes, levels 0/2, overrun 90, struct.
// [RULE11] Config word: index in byte1 plus byte0 bits 1..0, offset bytes 3..2.
// [RULE12] Type bits 7..5: off, below, above, bit cleared, bit set; 5..7 reserved.
// [RULE13] Format bits 4..2: 16/32/64 unsigned 1..3, signed 5..7, 0/4 none.
// [RULE14] Threshold uses bytes 7..0, 3..0 or 1..0 by width.
// [RULE15] Warning read returns stored config or threshold in write layout.
// [RULE16] Offsets 00h..0Fh select configs, 10h..1Fh thresholds.
// [RULE17] Master arms a warning with config at offset 0, then threshold at 10h.
// [RULE18] Active access level is zero after reset.
// [RULE19] Key change with wrong old key is rejected, key kept.
// [RULE20] Key offset above 4 or warning offset above 1Fh is rejected with error.
module ekw_key_warn
  import ekw_pkg::*;
#(
  parameter int ScanCycles = SCAN_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Monitored resource access
  output logic monStrobe,
  output ekw_mon_s monReq,
  input wire logic [63:0] monValue,
  // Error reporting
  output logic encError,
  output logic histLog,
  output logic [3:0] histWarnNo,
  output logic [2:0] activeLevel
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic ekw_cfg_s cfgDecode(input logic [31:0] w);
    ekw_cfg_s c;
    c.wtype = w[7:5];
    c.fmt = w[4:2];
    c.resIdx = {w[1:0], w[15:8]}; // [RULE11]
    c.resOff = w[31:16];
    return c;
  endfunction

  function automatic logic [64:0] extend(input logic [2:0] fmt, input logic [63:0] v);
    logic [64:0] r;
    r = {1'b0, v};
    if (fmt[1:0] == FW_16) begin
      r = {{49{fmt[2] & v[15]}}, v[15:0]};
    end else if (fmt[1:0] == FW_32) begin
      r = {{33{fmt[2] & v[31]}}, v[31:0]};
    end else if (fmt[1:0] == FW_64) begin
      r = {fmt[2] & v[63], v};
    end
    return r; // [RULE14]
  endfunction

  function automatic logic warnTrip(input ekw_cfg_s c, input logic [63:0] thr, input logic [63:0] v);
    logic [64:0] a;
    logic [64:0] b;
    logic t;
    a = extend(c.fmt, v);
    b = extend(c.fmt, thr);
    t = 1'b0;
    case (c.wtype)
      WT_BELOW: t = (c.fmt[1:0] != 2'h0) && ($signed(a) < $signed(b)); // [RULE13]
      WT_ABOVE: t = (c.fmt[1:0] != 2'h0) && ($signed(a) > $signed(b));
      WT_BIT_CLR: t = ((~v & thr) != 64'h0);
      WT_BIT_SET: t = ((v & thr) != 64'h0);
      default: t = 1'b0; // [RULE12]
    endcase
    return t;
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  logic [31:0] dataLo_r;
  logic [31:0] dataHi_r;
  logic [15:0] addr_r;
  logic [15:0] offset_r;
  logic release_r;
  logic txnErr_r;
  ekw_state_e state_r;
  logic [31:0] keys_r [NUM_LEVELS];
  logic [31:0] cfg_r [NUM_WARN];
  logic [63:0] thr_r [NUM_WARN];
  logic [15:0] tripped_r;
  logic wrPend_r;
  logic [7:0] wrAddr_r;

  // ****************************************
  // Bus decode
  // ****************************************
  wire addrPhase = hsel & htrans[1] & hready;
  wire [7:0] rdAddr = haddr[7:0];
  wire wrData = wrPend_r && (wrAddr_r == REG_DATA_LO);
  wire wrDataHi = wrPend_r && (wrAddr_r == REG_DATA_HI);
  wire wrAddr = wrPend_r && (wrAddr_r == REG_ADDR);
  wire wrOff = wrPend_r && (wrAddr_r == REG_OFFSET);
  wire wrCtrl = wrPend_r && (wrAddr_r == REG_CTRL);
  wire wrStat = wrPend_r && (wrAddr_r == REG_STATUS);
  wire wrLvl = wrPend_r && (wrAddr_r == REG_LEVEL);
  wire start = wrCtrl && (hwdata[7:0] == CTRL_START) && (state_r == ST_IDLE); // [RULE7]
  wire [31:0] statusWord = {tripped_r, 13'h0, encError, txnErr_r, release_r};
  wire [31:0] rdMux;
  assign rdMux = (rdAddr == REG_DATA_LO) ? dataLo_r :
                 (rdAddr == REG_DATA_HI) ? dataHi_r :
                 (rdAddr == REG_ADDR) ? {16'h0, addr_r} :
                 (rdAddr == REG_OFFSET) ? {16'h0, offset_r} :
                 (rdAddr == REG_STATUS) ? statusWord :
                 (rdAddr == REG_LEVEL) ? {29'h0, activeLevel} : 32'h0;

  // ****************************************
  // Transaction decode
  // ****************************************
  wire [9:0] resIdx = {addr_r[9:8], addr_r[7:0]};
  wire isKey = (resIdx == RID_KEY);
  wire isWarn = (resIdx == RID_WARN);
  wire doRead = addr_r[8 + ADDR_READ_BIT];
  wire doDef = addr_r[8 + ADDR_DEF_BIT];
  // Key level rides in the offset high byte; warning item in the low byte
  wire [7:0] offHi = offset_r[15:8];
  wire [7:0] offLo = offset_r[7:0];
  wire keyOffOk = (offLo == 8'h00) && (offHi <= MAX_LEVEL); // [RULE6] [RULE20]
  wire [2:0] keyLvl = offHi[2:0];
  wire keyMatch = keyOffOk && (keys_r[keyLvl] == dataHi_r); // [RULE4] [RULE19]
  wire keyErr = doRead || !keyMatch; // [RULE5]
  wire warnOffOk = (offHi == 8'h00) && (offLo <= MAX_WARN_OFF); // [RULE20]
  wire [3:0] warnNo = offLo[3:0];
  wire warnIsThr = offLo[WARN_THR_BIT]; // [RULE16]
  wire warnLvlOk = ({5'h0, activeLevel} >= WARN_WR_LVL);
  wire warnErr = !warnOffOk || (!doRead && !warnLvlOk);
  wire txnErr = doDef ? !(isKey || isWarn) : isKey ? keyErr : isWarn ? warnErr : 1'b1;
  wire [63:0] defWord;
  assign defWord = isKey ? {8'h0, DEF_TYPE, DEF_OVERRUN, KEY_WR_LVL, KEY_RD_LVL, DEF_SIZE, 6'h0, RID_KEY} // [RULE1]
                 : {8'h0, DEF_TYPE, DEF_OVERRUN, WARN_WR_LVL, WARN_RD_LVL, DEF_SIZE, 6'h0, RID_WARN}; // [RULE10]
  wire [63:0] warnRd = warnIsThr ? thr_r[warnNo] : {32'h0, cfg_r[warnNo]}; // [RULE15]
  wire [63:0] rdWord = doDef ? defWord : warnRd;
  wire execOk = (state_r == ST_EXEC) && !txnErr;
  wire loadRd = execOk && (doDef || doRead);
  wire keyWr = execOk && isKey && !doDef; // [RULE2] [RULE3]
  wire warnWr = execOk && isWarn && !doDef && !doRead;

  // ****************************************
  // Bus slave and parameter channel
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend_r <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr_r <= rdAddr;
        hrdata <= hwrite ? 32'h0 : rdMux;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dataLo_r <= 32'h0;
      dataHi_r <= 32'h0;
      addr_r <= 16'h0;
      offset_r <= 16'h0;
      activeLevel <= 3'h0; // [RULE18]
    end else begin
      if (loadRd) begin
        dataLo_r <= rdWord[31:0];
        dataHi_r <= rdWord[63:32];
      end else begin
        if (wrData) dataLo_r <= hwdata;
        if (wrDataHi) dataHi_r <= hwdata;
      end
      if (wrAddr) addr_r <= hwdata[15:0];
      if (wrOff) offset_r <= hwdata[15:0];
      if (wrLvl && (hwdata[7:0] <= MAX_LEVEL)) activeLevel <= hwdata[2:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      release_r <= 1'b1;
      txnErr_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_EXEC;
            release_r <= 1'b0;
          end
        end
        ST_EXEC: begin
          state_r <= ST_IDLE;
          release_r <= 1'b1;
          txnErr_r <= txnErr; // [RULE20]
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Keys survive only until reset; no non-volatile store behind them
  generate
    for (genvar k = 0; k < NUM_LEVELS; k++) begin : g_key
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          keys_r[k] <= KEY_DEFAULT[k];
        end else if (keyWr && (keyLvl == 3'(k))) begin
          keys_r[k] <= dataLo_r; // [RULE4]
        end
      end
    end
    for (genvar w = 0; w < NUM_WARN; w++) begin : g_warn
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          cfg_r[w] <= 32'h0;
          thr_r[w] <= 64'h0;
        end else if (warnWr && (warnNo == 4'(w))) begin
          if (warnIsThr) thr_r[w] <= {dataHi_r, dataLo_r}; // [RULE14]
          else cfg_r[w] <= dataLo_r; // [RULE11]
        end
      end
    end
  endgenerate

  // ****************************************
  // Once-per-second warning scan
  // ****************************************
  logic [31:0] tickCnt_r;
  ekw_scan_e scan_r;
  logic [3:0] scanIdx_r;
  wire tick = (tickCnt_r == 32'(ScanCycles - 1));
  wire ekw_cfg_s scanCfg = cfgDecode(cfg_r[scanIdx_r]);
  wire scanEn = (scanCfg.wtype != WT_OFF);
  wire trip = scanEn && warnTrip(scanCfg, thr_r[scanIdx_r], monValue);
  wire lastIdx = (scanIdx_r == 4'(NUM_WARN - 1));
  wire clrEnc = wrStat && hwdata[ST_ENC_ERR];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tickCnt_r <= 32'h0;
    end else begin
      tickCnt_r <= tick ? 32'h0 : tickCnt_r + 32'h1;
    end
  end

  // A scan still running at the next tick is not restarted; it takes 32 cycles
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scan_r <= SC_IDLE;
      scanIdx_r <= 4'h0;
      monStrobe <= 1'b0;
      monReq <= '0;
    end else begin
      monStrobe <= 1'b0;
      case (scan_r)
        SC_IDLE: begin
          if (tick) begin
            scan_r <= SC_REQ; // [RULE8]
            scanIdx_r <= 4'h0;
          end
        end
        SC_REQ: begin
          monStrobe <= scanEn;
          monReq <= {scanCfg.resIdx, scanCfg.resOff};
          scan_r <= SC_EVAL;
        end
        SC_EVAL: begin
          scanIdx_r <= scanIdx_r + 4'h1;
          scan_r <= lastIdx ? SC_IDLE : SC_REQ;
        end
        default: scan_r <= SC_IDLE;
      endcase
    end
  end

  // Set beats clear when a trip lands in the same cycle as the clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      encError <= 1'b0;
      histLog <= 1'b0;
      histWarnNo <= 4'h0;
      tripped_r <= 16'h0;
    end else begin
      histLog <= 1'b0;
      if (clrEnc) begin
        encError <= 1'b0;
        tripped_r <= 16'h0;
      end
      if ((scan_r == SC_EVAL) && trip) begin
        encError <= 1'b1; // [RULE9]
        tripped_r[scanIdx_r] <= 1'b1;
        histLog <= 1'b1;
        histWarnNo <= scanIdx_r;
      end
    end
  end

endmodule

/* File: test/ekw_key_warn_asserts.sv */
// Concurrent checks on the key and warning resource block ports.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/1ps
module ekw_key_warn_asserts
  import ekw_pkg::*;
#(
  parameter int ScanCycles = SCAN_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Monitor and errors
  input wire logic monStrobe,
  input wire ekw_mon_s monReq,
  input wire logic [63:0] monValue,
  input wire logic encError,
  input wire logic histLog,
  input wire logic [3:0] histWarnNo,
  input wire logic [2:0] activeLevel
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire addrTaken = hsel & htrans[1] & hready;
  sequence sStrobeOnce;
    monStrobe ##1 !monStrobe;
  endsequence
  sequence sTripReport;
    histLog && encError ##1 !histLog;
  endsequence
  AST_LVL_RST: assert property (!$past(nrst) |-> (activeLevel == 3'h0) [*3])
    else $error("active level not zero after reset");
  AST_RDY: assert property ($past(nrst) |-> hreadyout)
    else $error("slave not ready");
  AST_RESP: assert property (hresp == 1'h0)
    else $error("response not okay");
  AST_RD_STANDS: assert property (!addrTaken |=> $stable(hrdata))
    else $error("read data changed without a transfer");
  AST_STROBE: assert property (monStrobe |-> sStrobeOnce)
    else $error("monitor strobe longer than one cycle");
  AST_TRIP_CAUSE: assert property (histLog |-> $past(monStrobe))
    else $error("trip without evaluation");
  AST_TRIP_REPORT: assert property (histLog |-> sTripReport)
    else $error("trip not reported as encoder error");
  AST_ERR_ROSE: assert property ($rose(encError) |-> histLog)
    else $error("encoder error without history log");
endmodule

bind ekw_key_warn ekw_key_warn_asserts #(.ScanCycles(ScanCycles)) asrt_u (
  .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .monStrobe(monStrobe), .monReq(monReq), .monValue(monValue),
  .encError(encError), .histLog(histLog), .histWarnNo(histWarnNo), .activeLevel(activeLevel)
);

/* File: test/ekw_mon_src.sv */
// Model of the monitored-value source beside the warning scanner.
// Assumes the scanner samples the value in the cycle in which its strobe stands.
`timescale 1ns/1ps
module ekw_mon_src (
  // Clock
  input wire logic mclk,
  // Request and value
  input wire logic monStrobe,
  input wire logic [63:0] srcValue,
  output logic [63:0] monValue
);
  logic [63:0] idle_r = 64'h0;
  // Outside the strobe cycle the value toggles, so a sample in the wrong cycle differs from srcValue unless srcValue is all zeros or all ones
  always @(posedge mclk) begin
    idle_r <= ~idle_r;
  end
  // Answer stands while the registered strobe does; the scanner compares at the end of that cycle
  assign monValue = monStrobe ? srcValue : idle_r;
endmodule

/* File: test/encoder_key_and_warning_resources_tb.sv */
// Self-checking bench for the key and warning resource block.
// Assumes zero-wait AHB-Lite answers and a scan period shortened to 40 cycles.
`timescale 1ns/1ps
`define EKW_CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module encoder_key_and_warning_resources_tb
  import ekw_pkg::*;
;
  // ****************************************
  // Signals and instances
  // ****************************************
  typedef struct {logic [31:0] lo, hi; logic [15:0] a, o; logic [1:0] f; logic [31:0] eLo, eHi;} ekw_row_s;
  logic mclk, nrst, hsel, hwrite, hreadyout, hresp, monStrobe, encError, histLog;
  logic [31:0] haddr, hwdata, hrdata, r, st, ro, rh;
  logic [1:0] htrans;
  logic [2:0] hsize, activeLevel;
  logic [3:0] histWarnNo;
  logic [63:0] monValue, srcValue;
  logic [15:0] lastOff;
  ekw_mon_s monReq;
  int miscompares = 0, checked = 0, cyc = 0, stamp = 0, gap = 0;
  ekw_row_s rows[19] = '{
    '{32'h0, 32'h0, 16'h8105, 16'h0, 2'h2, 32'h0F080105, 32'h00185A00},
    '{32'h0, 32'h0, 16'h8107, 16'h0, 2'h2, 32'h00080107, 32'h00185A02},
    '{32'h0, 32'h0, 16'h4105, 16'h0, 2'h1, 32'h0, 32'h0},
    '{32'h12345678, 32'h31313131, 16'h3D05, 16'h0200, 2'h1, 32'h0, 32'h0},
    '{32'h12345678, 32'h32323232, 16'h3D05, 16'h0200, 2'h0, 32'h0, 32'h0},
    '{32'h32323232, 32'h12345678, 16'h3D05, 16'h0200, 2'h0, 32'h0, 32'h0},
    '{32'h0, 32'h34343434, 16'h3D05, 16'h0400, 2'h0, 32'h0, 32'h0},
    '{32'h0, 32'h0, 16'h3D05, 16'h0500, 2'h1, 32'h0, 32'h0},
    '{32'h0, 32'h0, 16'h3D05, 16'h0001, 2'h1, 32'h0, 32'h0},
    '{32'h0000C134, 32'h0, 16'h3907, 16'h0000, 2'h1, 32'h0, 32'h0},
    '{32'h0000C134, 32'h0, 16'h3907, 16'h0000, 2'h0, 32'h0, 32'h0},
    '{32'h0000E803, 32'h0, 16'h3907, 16'h0010, 2'h0, 32'h0, 32'h0},
    '{32'h0, 32'h0, 16'h7907, 16'h0000, 2'h2, 32'h0000C134, 32'h0},
    '{32'h0, 32'h0, 16'h7907, 16'h0010, 2'h2, 32'h0000E803, 32'h0},
    '{32'h89ABCDEF, 32'h01234567, 16'h3907, 16'h001F, 2'h0, 32'h0, 32'h0},
    '{32'h0, 32'h0, 16'h7907, 16'h001F, 2'h2, 32'h89ABCDEF, 32'h01234567},
    '{32'h0, 32'h0, 16'h3907, 16'h0020, 2'h1, 32'h0, 32'h0},
    '{32'h00125544, 32'h0, 16'h3907, 16'h0001, 2'h0, 32'h0, 32'h0},
    '{32'h00000100, 32'h0, 16'h3907, 16'h0011, 2'h0, 32'h0, 32'h0}
  };
  ekw_key_warn #(.ScanCycles(40)) dut_u (
    .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .monStrobe(monStrobe), .monReq(monReq), .monValue(monValue),
    .encError(encError), .histLog(histLog), .histWarnNo(histWarnNo), .activeLevel(activeLevel)
  );
  ekw_mon_src src_u (.mclk(mclk), .monStrobe(monStrobe), .srcValue(srcValue), .monValue(monValue));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'h1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge mclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  // Loads buffer, address and offset, starts, then polls the release flag
  task automatic txn(input logic [31:0] lo, hi, input logic [15:0] a, o);
    logic [31:0] q;
    ahb(1'h1, REG_DATA_LO, lo, q); ahb(1'h1, REG_DATA_HI, hi, q);
    ahb(1'h1, REG_ADDR, {16'h0, a}, q); ahb(1'h1, REG_OFFSET, {16'h0, o}, q);
    ahb(1'h1, REG_CTRL, {24'h0, CTRL_START}, q);
    do ahb(1'h0, REG_STATUS, 32'h0, st); while (st[ST_RELEASE] !== 1'h1);
    ahb(1'h0, REG_DATA_LO, 32'h0, ro); ahb(1'h0, REG_DATA_HI, 32'h0, rh);
  endtask

  // ****************************************
  // Clock, timeout, scan monitor
  // ****************************************
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (monStrobe === 1'h1 && monReq.resIdx === 10'h055) begin
      gap <= cyc - stamp; stamp <= cyc; lastOff <= monReq.resOff;
    end
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    mclk = 0; nrst = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0; srcValue = 0;
    repeat (5) @(posedge mclk);
    nrst <= 1'h1;
    @(negedge mclk); `EKW_CHK(activeLevel, 3'h0)
    for (int i = 0; i < 19; i++) begin
      if (i == 10) ahb(1'h1, REG_LEVEL, 32'h2, r);
      txn(rows[i].lo, rows[i].hi, rows[i].a, rows[i].o);
      `EKW_CHK(st[ST_TXN_ERR], rows[i].f[0])
      if (rows[i].f[1]) begin
        `EKW_CHK(ro, rows[i].eLo)
        `EKW_CHK(rh, rows[i].eHi)
      end
    end
    // Warning 1 watches index 055h for a value above 100h
    srcValue <= 64'h200;
    for (int n = 0; n < 200 && histLog !== 1'h1; n++) @(negedge mclk);
    `EKW_CHK(histWarnNo, 4'h1)
    `EKW_CHK(encError, 1'h1)
    repeat (100) @(posedge mclk);
    `EKW_CHK(gap, 40)
    `EKW_CHK(lastOff, 16'h0012)
    ahb(1'h0, REG_STATUS, 32'h0, r); `EKW_CHK(r, 32'h00020005)
    srcValue <= 64'h0;
    repeat (100) @(posedge mclk);
    ahb(1'h1, REG_STATUS, 32'h4, r);
    ahb(1'h0, REG_STATUS, 32'h0, r); `EKW_CHK(r, 32'h00000001)
    ahb(1'h0, 8'h1C, 32'h0, r); `EKW_CHK(r, 32'h0)
    // Reset in mid-run must restore level and keys
    @(posedge mclk) nrst <= 1'h0;
    repeat (5) @(posedge mclk);
    nrst <= 1'h1;
    @(negedge mclk); `EKW_CHK(activeLevel, 3'h0)
    txn(32'h1, 32'h34343434, 16'h3D05, 16'h0400); `EKW_CHK(st[ST_TXN_ERR], 1'h0)
    end_sim();
  end
endmodule
